// >>> include/csc_pkg.sv
/*
 * Package for the CPU stop-clock and event control block: register
 * offsets, control bit positions, reset values, tick timing and types.
 * Assumes a 40 MHz device clock and a classic Wishbone register bus.
 */
package csc_pkg;

   // Register byte offsets
   localparam logic [7:0] ADR_CTRL = 8'h00; // power_mgmt_control
   localparam logic [7:0] ADR_HIGH = 8'h04; // throttle_high_time
   localparam logic [7:0] ADR_LOW = 8'h08; // throttle_low_time
   localparam logic [7:0] ADR_SEE = 8'h0c; // system_event_enable
   localparam logic [7:0] ADR_SMIEN = 8'h10; // IRQ to SMI enables
   localparam logic [7:0] ADR_ISTAT = 8'h14; // sticky event status, RO
   localparam logic [7:0] ADR_ICLR = 8'h18; // status clear, WO
   localparam logic [7:0] ADR_IEN = 8'h1c; // interrupt enables
   localparam logic [7:0] ADR_STAT = 8'h20; // live state, RO

   // Control register bit positions
   localparam int CB_SCALE_EN = 0; // Periodic clock scaling
   localparam int CB_SW_ASSERT = 1; // Write 1: assert halt
   localparam int CB_SW_NEGATE = 2; // Write 1: negate halt
   localparam int CB_HALT_EN = 3; // Needed for software assert; scaling halts without it
   localparam int CB_SMI_GATE = 4; // smi_gate_bit, hw set, sw clear
   localparam int CB_SMI_APIC = 5; // SMI through APIC, not pin
   localparam int CB_NO_WAIT = 6; // Skip halt_grant_cycle wait

   // Event status bit positions
   localparam int EV_GRANT = 0;
   localparam int EV_BREAK = 1;
   localparam int EV_SYSEVT = 2;
   localparam int EV_SMI = 3;
   localparam int EV_W = 4;

   // Reset values
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_HIGH = 8'hff;
   localparam logic [7:0] RST_LOW = 8'h00;
   localparam logic [15:0] RST_SEE = 16'h0000;
   localparam logic [15:0] RST_SMIEN = 16'h0000;

   // Throttle tick: 32 us at 40 MHz
   localparam int TICK_NS = 32000;
   localparam int CLK_PERIOD_NS = 25;
   localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   localparam logic [10:0] TICK_LAST = 11'(TICK_CYCLES - 1);

   // Wishbone request from the master
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } csc_wb_req_type;

   // Wishbone answer to the master
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } csc_wb_rsp_type;

endpackage

// >>> rtl/csc_ctrl.sv
/*
 * CPU stop-clock throttle, halt grant tracking, IRQ system events and
 * SMI delivery, with a Wishbone register slave and an interrupt line.
 * Assumes IRQ pins are asynchronous, the halt grant strobe comes from
 * PCI decode logic on i_clk, and i_break_event is on i_clk too.
 */
// Added by the designer: the register addresses and register access over Wishbone.
// Functional notes
// - While halt is negated an enabled break reloads the high-time count.
// - With grant wait disabled the low countdown starts at once.
// - An enabled break negates halt, as does low-time expiry.
// - In the base variant the grant wait cannot be skipped.
// - With control bit 6 clear the first grant cycle is acted on.
// - Each CPU sharing the halt line sends a grant, forwarded to PCI.
// - SMI goes out on the dedicated pin or through the I/O APIC.
// - An SMI-enabled IRQ stays blocked until software clears the gate.
// - Each of 14 IRQs is a system event source enabled by bits [15:0].
// - An enabled IRQ system event reloads the idle timer, negates halt.
// - Enabled IRQs are sampled as level, active high activity.
// - Negation loads high time, assertion loads low time, act at zero.
// - The throttle timer steps once per 32 us tick on 8-bit counts.
// - With grant wait on, the low countdown holds until a grant.
`timescale 1ns/1ps

module csc_ctrl #(
   parameter bit ALLOW_NO_WAIT = 1'b1,
   parameter logic [15:0] IRQ_VALID = 16'hdffb
) (
   input wire logic i_clk, // 40 MHz clock
   input wire logic i_resetn, // Async reset, active low
   input wire csc_pkg::csc_wb_req_type i_wb, // Wishbone request
   output csc_pkg::csc_wb_rsp_type o_wb, // Wishbone answer
   input wire logic [15:0] i_irq, // IRQ pins, async
   input wire logic i_halt_grant, // Grant cycle seen, pulse
   input wire logic i_break_event, // Other break source, pulse
   output logic o_cpu_clock_halt_n, // Halt output, low = halt
   output logic o_sys_mgmt_irq_n, // SMI pin, active low
   output logic o_apic_smi, // SMI request to APIC
   output logic o_idle_reload, // Idle timer reload, high while a system event is active
   output logic o_irq // Event interrupt, level
);
   import csc_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_HIGH = 4'b0010,
      ST_WAIT = 4'b0100,
      ST_LOW = 4'b1000
   } csc_state_type;

   ////////////////////////////////////////////////////////////////////
   // Registers and state
   csc_state_type st_r, st_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic halt_n_r, halt_n_nxt;
   logic pend_r, pend_nxt;
   logic [10:0] pre_r;
   logic [7:0] ctrl_r;
   logic [7:0] high_r;
   logic [7:0] low_r;
   logic [15:0] see_r;
   logic [15:0] smien_r;
   logic [EV_W-1:0] istat_r;
   logic [EV_W-1:0] ien_r;
   logic [15:0] irq_m_r, irq_s_r;
   logic ack_r;
   logic [31:0] rdat_r;
   logic idle_r;

   ////////////////////////////////////////////////////////////////////
   // Bus decode
   wire req = i_wb.cyc & i_wb.stb & ~ack_r;
   // Writes land at the edge where the master sees ack high
   wire wr = i_wb.cyc & i_wb.stb & ack_r & i_wb.we;
   wire [15:0] bmask = {{8{i_wb.sel[1]}}, {8{i_wb.sel[0]}}};
   wire wr_ctrl = wr & (i_wb.adr == ADR_CTRL) & i_wb.sel[0];
   wire wr_high = wr & (i_wb.adr == ADR_HIGH) & i_wb.sel[0];
   wire wr_low = wr & (i_wb.adr == ADR_LOW) & i_wb.sel[0];
   wire wr_see = wr & (i_wb.adr == ADR_SEE);
   wire wr_smien = wr & (i_wb.adr == ADR_SMIEN);
   wire wr_iclr = wr & (i_wb.adr == ADR_ICLR) & i_wb.sel[0];
   wire wr_ien = wr & (i_wb.adr == ADR_IEN) & i_wb.sel[0];
   wire [7:0] wd8 = i_wb.dat[7:0];
   wire [15:0] wd16 = i_wb.dat[15:0];

   // Control fields
   wire scale_en = ctrl_r[CB_SCALE_EN];
   wire halt_en = ctrl_r[CB_HALT_EN];
   wire gate = ctrl_r[CB_SMI_GATE];
   wire route_apic = ctrl_r[CB_SMI_APIC];
   wire no_wait = ALLOW_NO_WAIT & ctrl_r[CB_NO_WAIT];
   wire sw_assert = wr_ctrl & wd8[CB_SW_ASSERT] & wd8[CB_HALT_EN];
   wire sw_negate = wr_ctrl & (wd8[CB_SW_NEGATE] | ~wd8[CB_HALT_EN]);

   // Events from synchronised IRQ levels
   wire [15:0] irq_act = irq_s_r & IRQ_VALID;
   wire sys_evt = |(irq_act & see_r);
   wire brk = sys_evt | i_break_event;
   wire smi_hit = |(irq_act & smien_r) & ~gate;
   wire tick = (pre_r == 11'h000);

   ////////////////////////////////////////////////////////////////////
   // IRQ pin synchroniser, two flops
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         irq_m_r <= 16'h0000;
         irq_s_r <= 16'h0000;
      end else begin
         irq_m_r <= i_irq;
         irq_s_r <= irq_m_r;
      end
   end

   // 32 us tick divider
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pre_r <= TICK_LAST;
      end else begin
         pre_r <= tick ? TICK_LAST : pre_r - 11'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Throttle state machine next state
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      halt_n_nxt = halt_n_r;
      pend_nxt = pend_r;
      case (st_r)
         ST_IDLE: begin
            if (sw_assert) begin
               halt_n_nxt = 1'b0;
               cnt_nxt = low_r;
               st_nxt = no_wait ? ST_LOW : ST_WAIT;
               pend_nxt = 1'b0;
            end else if (scale_en) begin
               cnt_nxt = high_r;
               st_nxt = ST_HIGH;
            end
         end
         ST_HIGH: begin
            if (!scale_en || sw_negate) begin
               st_nxt = ST_IDLE;
            end else if (brk) begin
               cnt_nxt = high_r;
            end else if (sw_assert || (tick && cnt_r == 8'h00)) begin
               halt_n_nxt = 1'b0;
               cnt_nxt = low_r;
               st_nxt = no_wait ? ST_LOW : ST_WAIT;
               pend_nxt = 1'b0;
            end else if (tick) begin
               cnt_nxt = cnt_r - 8'h01;
            end
         end
         ST_WAIT: begin
            // Break negation waits for the grant cycle
            if (sw_negate) begin
               halt_n_nxt = 1'b1;
               cnt_nxt = high_r;
               st_nxt = scale_en ? ST_HIGH : ST_IDLE;
            end else if (i_halt_grant) begin
               if (pend_r || brk) begin
                  halt_n_nxt = 1'b1;
                  cnt_nxt = high_r;
                  st_nxt = scale_en ? ST_HIGH : ST_IDLE;
               end else begin
                  st_nxt = ST_LOW;
               end
            end else if (brk) begin
               pend_nxt = 1'b1;
            end
         end
         ST_LOW: begin
            // Later grants from a second CPU are ignored
            if (sw_negate || brk || (tick && cnt_r == 8'h00)) begin
               halt_n_nxt = 1'b1;
               cnt_nxt = high_r;
               st_nxt = scale_en ? ST_HIGH : ST_IDLE;
            end else if (tick) begin
               cnt_nxt = cnt_r - 8'h01;
            end
         end
         default: begin
            st_nxt = ST_IDLE;
            halt_n_nxt = 1'b1;
         end
      endcase
   end

   // Throttle state flops
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_r <= ST_IDLE;
         cnt_r <= 8'h00;
         halt_n_r <= 1'b1;
         pend_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         halt_n_r <= halt_n_nxt;
         pend_r <= pend_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Control register; hardware setting the gate wins over a clear
   wire [7:0] ctrl_w = wr_ctrl ?
      (wd8 & ~8'h06) : ctrl_r;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl_r <= RST_CTRL;
      end else begin
         ctrl_r <= ctrl_w | {3'h0, smi_hit, 4'h0};
      end
   end

   // Timing and enable registers
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         high_r <= RST_HIGH;
         low_r <= RST_LOW;
         see_r <= RST_SEE;
         smien_r <= RST_SMIEN;
         ien_r <= '0;
      end else begin
         if (wr_high) high_r <= wd8;
         if (wr_low) low_r <= wd8;
         if (wr_see) see_r <= (see_r & ~bmask) | (wd16 & bmask);
         if (wr_smien) smien_r <= (smien_r & ~bmask) | (wd16 & bmask);
         if (wr_ien) ien_r <= wd8[EV_W-1:0];
      end
   end

   // Sticky event status, set wins over clear
   wire [EV_W-1:0] ev_set = {smi_hit, sys_evt, brk & ~halt_n_r,
      i_halt_grant & (st_r == ST_WAIT)};
   wire [EV_W-1:0] ev_clr = wr_iclr ? wd8[EV_W-1:0] : '0;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         istat_r <= '0;
      end else begin
         istat_r <= (istat_r & ~ev_clr) | ev_set;
      end
   end

   // Idle timer reload, registered level of the system event
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         idle_r <= 1'b0;
      end else begin
         idle_r <= sys_evt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read mux, unmapped reads return zero
   wire [31:0] rd_mux =
      (i_wb.adr == ADR_CTRL) ? {24'h0, ctrl_r} :
      (i_wb.adr == ADR_HIGH) ? {24'h0, high_r} :
      (i_wb.adr == ADR_LOW) ? {24'h0, low_r} :
      (i_wb.adr == ADR_SEE) ? {16'h0, see_r} :
      (i_wb.adr == ADR_SMIEN) ? {16'h0, smien_r} :
      (i_wb.adr == ADR_ISTAT) ? {28'h0, istat_r} :
      (i_wb.adr == ADR_IEN) ? {28'h0, ien_r} :
      (i_wb.adr == ADR_STAT) ? {15'h0, pend_r, ~halt_n_r, 3'h0,
                                st_r, cnt_r} : 32'h0;

   // Bus answer, one wait state
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ack_r <= 1'b0;
         rdat_r <= 32'h0;
      end else begin
         ack_r <= req;
         if (req && !i_wb.we) rdat_r <= rd_mux;
      end
   end

   // Outputs
   assign o_wb = '{ack: ack_r, dat: rdat_r};
   assign o_cpu_clock_halt_n = halt_n_r;
   assign o_sys_mgmt_irq_n = ~(gate & ~route_apic);
   assign o_apic_smi = gate & route_apic;
   assign o_idle_reload = idle_r;
   assign o_irq = |(istat_r & ien_r);

   ////////////////////////////////////////////////////////////////////
   // Assertions
   property p_high_reload;
      @(posedge i_clk) disable iff (!i_resetn)
      (st_r == ST_HIGH && scale_en && !sw_negate && brk)
         |=> (cnt_r == $past(high_r)) && halt_n_r;
   endproperty
   a_high_reload: assert property (p_high_reload)
      else $error("high time not reloaded on break");

   property p_no_wait;
      @(posedge i_clk) disable iff (!i_resetn)
      (st_r == ST_HIGH && scale_en && !sw_negate && !brk && tick &&
       cnt_r == 8'h00 && no_wait) |=> (st_r == ST_LOW) && !halt_n_r;
   endproperty
   a_no_wait: assert property (p_no_wait)
      else $error("low countdown did not start at once");

   property p_break_negate;
      @(posedge i_clk) disable iff (!i_resetn)
      (st_r == ST_LOW && brk) |=> halt_n_r;
   endproperty
   a_break_negate: assert property (p_break_negate)
      else $error("break did not negate halt");

   property p_base_wait;
      @(posedge i_clk) disable iff (!i_resetn)
      (!ALLOW_NO_WAIT && halt_n_r) ##1 !halt_n_r |-> st_r == ST_WAIT;
   endproperty
   a_base_wait: assert property (p_base_wait)
      else $error("base variant skipped grant wait");

   property p_hold_wait;
      @(posedge i_clk) disable iff (!i_resetn)
      (st_r == ST_WAIT && !i_halt_grant && !sw_negate)
         |=> (st_r == ST_WAIT) && $stable(cnt_r);
   endproperty
   a_hold_wait: assert property (p_hold_wait)
      else $error("low countdown ran without grant");

   property p_assert_load;
      @(posedge i_clk) disable iff (!i_resetn)
      $fell(halt_n_r) |-> cnt_r == $past(low_r);
   endproperty
   a_assert_load: assert property (p_assert_load)
      else $error("low time not loaded on assertion");

   property p_tick_only;
      @(posedge i_clk) disable iff (!i_resetn)
      (st_r == ST_LOW && !tick && !brk && !sw_negate) |=> $stable(cnt_r);
   endproperty
   a_tick_only: assert property (p_tick_only)
      else $error("timer stepped without tick");

   property p_gate_hold;
      @(posedge i_clk) disable iff (!i_resetn)
      (gate && !wr_ctrl) |=> gate && !smi_hit;
   endproperty
   a_gate_hold: assert property (p_gate_hold)
      else $error("SMI gate dropped without software clear");

   property p_sys_evt;
      @(posedge i_clk) disable iff (!i_resetn)
      (sys_evt && st_r == ST_LOW) |=> o_idle_reload && halt_n_r;
   endproperty
   a_sys_evt: assert property (p_sys_evt)
      else $error("system event did not reload idle timer");

   property p_idle_negated;
      @(posedge i_clk) disable iff (!i_resetn)
      (st_r == ST_IDLE) |-> halt_n_r;
   endproperty
   a_idle_negated: assert property (p_idle_negated)
      else $error("halt asserted while idle");

   property p_smi_route;
      @(posedge i_clk) disable iff (!i_resetn)
      !o_sys_mgmt_irq_n |-> !o_apic_smi && !route_apic;
   endproperty
   a_smi_route: assert property (p_smi_route)
      else $error("SMI delivered on both paths");

endmodule

// >>> verif/cpu_stop_clock_event_control_bench.sv
/*
 * Self-checking bench for the stop-clock and event control block.
 * Assumes csc_pkg, csc_ctrl and the CPU model are compiled first.
 */
`timescale 1ns/1ps

module cpu_stop_clock_event_control_bench;
   import csc_pkg::*;
   localparam logic [15:0] IRQ_OK = 16'hdffb; // 14 event sources
   localparam int T = TICK_CYCLES;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   csc_wb_req_type wb_req = '0;
   csc_wb_rsp_type wb_rsp;
   logic [15:0] irq = 16'h0000;
   logic brk = 1'b0;
   logic grant, halt_n, base_halt_n, smi_n, apic_smi, idle_rl, ev_irq;
   logic m_on = 1'b1;
   logic m_two = 1'b1;
   logic [15:0] m_dly = 16'h05dc;
   logic [15:0] rnd = 16'h0039;
   logic [31:0] q;
   logic e;
   int fail_count = 0;
   int checks_done = 0;
   int t;
   int regm[int];

   always #12.5 clk = ~clk;

   csc_ctrl i_csc_ctrl (.i_clk(clk), .i_resetn(resetn), .i_wb(wb_req),
      .o_wb(wb_rsp), .i_irq(irq), .i_halt_grant(grant),
      .i_break_event(brk), .o_cpu_clock_halt_n(halt_n),
      .o_sys_mgmt_irq_n(smi_n), .o_apic_smi(apic_smi),
      .o_idle_reload(idle_rl), .o_irq(ev_irq));
   csc_ctrl #(.ALLOW_NO_WAIT(1'b0)) i_csc_ctrl_base (.i_clk(clk),
      .i_resetn(resetn), .i_wb(wb_req), .o_wb(), .i_irq(irq),
      .i_halt_grant(grant), .i_break_event(brk),
      .o_cpu_clock_halt_n(base_halt_n), .o_sys_mgmt_irq_n(),
      .o_apic_smi(), .o_idle_reload(), .o_irq());
   csc_cpu_model i_csc_cpu_model (.i_clk(clk), .i_resetn(resetn),
      .i_halt_n(halt_n), .i_on(m_on), .i_two(m_two), .i_delay(m_dly),
      .o_grant(grant));

   ////////////////////////////////////////////////////////////////////
   // Helpers: random source, bus cycles, comparisons
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic int mask_of(input logic [7:0] a);
      case (a)
         ADR_HIGH, ADR_LOW: return 32'hff;
         ADR_SEE, ADR_SMIEN: return 32'hffff;
         ADR_IEN: return 32'hf;
         default: return 0;
      endcase
   endfunction

   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] lo,
                      input logic [31:0] hi);
      checks_done++;
      if (^g === 1'bx || g < lo || g > hi) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, lo);
      end
   endtask

   // Classic cycle held until ack, then one idle cycle
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      wb_req <= '{1'b1, 1'b1, we, a, 4'hf, d};
      do begin
         @(posedge clk);
         n++;
      end while (wb_rsp.ack !== 1'b1 && n < 64);
      q = wb_rsp.dat;
      if (n >= 64) begin
         fail_count++;
         stop_test();
      end
      wb_req <= '0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
      if (mask_of(a) != 0) regm[a] = d & mask_of(a);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      wb(1'b0, a, 32'h0);
      chk(q, x, x);
   endtask

   task automatic wait_halt(input logic v, input int lim);
      t = 0;
      while (halt_n !== v && t < lim) begin
         @(posedge clk);
         t++;
      end
   endtask

   task automatic pulse_brk;
      brk <= 1'b1;
      @(posedge clk);
      brk <= 1'b0;
      @(posedge clk);
   endtask

   // Watchdog against a hang
   initial begin
      #2500000;
      fail_count++;
      stop_test();
   end

   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      regm[ADR_HIGH] = RST_HIGH;
      regm[ADR_LOW] = RST_LOW;
      regm[ADR_SEE] = RST_SEE;
      regm[ADR_SMIEN] = RST_SMIEN;
      regm[ADR_IEN] = 0;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      // Reset state, read-only and unmapped places, random data
      chk(32'(halt_n), 1, 1);
      foreach (regm[k]) rd(8'(k), regm[k]);
      rd(ADR_CTRL, RST_CTRL);
      wr(ADR_ISTAT, 32'hf);
      rd(ADR_ISTAT, 32'h0);
      rd(ADR_ICLR, 32'h0);
      rd(8'h24, 32'h0);
      repeat (3) begin
         foreach (regm[k]) begin
            wr(8'(k), {rnd, rnd});
            rnd = lfsr(rnd);
         end
         foreach (regm[k]) rd(8'(k), regm[k]);
      end
      // Periodic scaling, two slow CPUs answering
      wr(ADR_HIGH, 32'h1);
      wr(ADR_LOW, 32'h1);
      wr(ADR_IEN, 32'h0);
      wr(ADR_SEE, 32'h0);
      wr(ADR_SMIEN, 32'h0);
      wr(ADR_ICLR, 32'hf);
      wr(ADR_CTRL, 32'h09);
      wait_halt(1'b0, 3*T);
      chk(t, T - 4, 2*T + 4);
      wait_halt(1'b1, 5*T);
      chk(t, m_dly + T, m_dly + 2*T + 6);
      rd(ADR_ISTAT, 32'h1);
      // Break while halted, interrupt raised, masked and cleared
      m_dly <= 16'h000a;
      wr(ADR_IEN, 32'h2);
      wait_halt(1'b0, 3*T);
      repeat (60) @(posedge clk);
      pulse_brk();
      wait_halt(1'b1, 4);
      chk(t, 0, 3);
      chk(32'(ev_irq), 1, 1);
      wr(ADR_IEN, 32'h0);
      chk(32'(ev_irq), 0, 0);
      rd(ADR_ISTAT, 32'h3);
      wr(ADR_ICLR, 32'h3);
      wr(ADR_IEN, 32'h2);
      chk(32'(ev_irq), 0, 0);
      // Repeated breaks keep the halt line released
      repeat (5) begin
         repeat (900) @(posedge clk);
         pulse_brk();
         chk(32'(halt_n), 1, 1);
      end
      wait_halt(1'b0, 3*T);
      chk(t, T - 4, 2*T + 4);
      // Grant wait skipped, base variant keeps waiting
      wr(ADR_CTRL, 32'h04);
      chk(32'(halt_n), 1, 1);
      m_on <= 1'b0;
      wr(ADR_CTRL, 32'h49);
      wait_halt(1'b0, 3*T);
      wait_halt(1'b1, 3*T);
      chk(t, T - 2, 2*T + 4);
      chk(32'(base_halt_n), 0, 0);
      wr(ADR_CTRL, 32'h04);
      chk(32'(base_halt_n), 1, 1);
      // Every IRQ input as a level event source
      m_on <= 1'b1;
      m_dly <= 16'h0014;
      for (int p = 0; p < 2; p++) begin
         rnd = lfsr(rnd);
         wr(ADR_SEE, p == 0 ? 32'hffff : {16'h0, rnd});
         for (int b = 0; b < 16; b++) begin
            e = IRQ_OK[b] & regm[ADR_SEE][b];
            irq[b] <= 1'b1;
            repeat (6) @(posedge clk);
            chk(32'(idle_rl), 32'(e), 32'(e));
            repeat (6) @(posedge clk);
            chk(32'(idle_rl), 32'(e), 32'(e));
            irq[b] <= 1'b0;
            repeat (6) @(posedge clk);
            chk(32'(idle_rl), 0, 0);
         end
      end
      // Enabled IRQ event releases a held CPU
      wr(ADR_SEE, 32'h0008);
      wr(ADR_CTRL, 32'h0a);
      wait_halt(1'b0, 8);
      chk(t, 0, 3);
      repeat (60) @(posedge clk);
      irq[3] <= 1'b1;
      wait_halt(1'b1, 8);
      chk(t, 1, 6);
      irq[3] <= 1'b0;
      // SMI through the pin, then through the APIC
      wr(ADR_SMIEN, 32'h0008);
      for (int r = 0; r < 2; r++) begin
         wr(ADR_CTRL, r ? 32'h20 : 32'h00);
         irq[3] <= 1'b1;
         repeat (8) @(posedge clk);
         irq[3] <= 1'b0;
         repeat (20) @(posedge clk);
         chk(32'(smi_n), r, r);
         chk(32'(apic_smi), r, r);
         // A second IRQ while the gate is set fires no new SMI
         wr(ADR_ICLR, 32'hf);
         irq[3] <= 1'b1;
         repeat (8) @(posedge clk);
         irq[3] <= 1'b0;
         repeat (4) @(posedge clk);
         rd(ADR_ISTAT, 32'h4);
         rd(ADR_CTRL, r ? 32'h30 : 32'h10);
         wr(ADR_CTRL, r ? 32'h20 : 32'h00);
         chk(32'(smi_n), 1, 1);
         chk(32'(apic_smi), 0, 0);
      end
      stop_test();
   end
endmodule

// >>> verif/csc_cpu_model.sv
/*
 * Model of the host CPUs behind the PCI host bridge: each CPU answers
 * a falling halt line with one grant cycle, seen here as a pulse.
 * Assumes the halt line changes just after a rising clock edge.
 */
`timescale 1ns/1ps

module csc_cpu_model (
   input wire logic i_clk, // Device clock
   input wire logic i_resetn, // Reset, active low
   input wire logic i_halt_n, // Halt line, low = halt
   input wire logic i_on, // CPUs answer halts
   input wire logic i_two, // Second CPU shares the line
   input wire logic [15:0] i_delay, // Cycles before each grant
   output logic o_grant // Grant cycle pulse on PCI
);
   // One CPU: wait, then a single-cycle grant
   task automatic grant_one;
      repeat (i_delay) @(posedge i_clk);
      o_grant <= 1'b1;
      @(posedge i_clk);
      o_grant <= 1'b0;
   endtask

   initial o_grant = 1'b0;

   // Every CPU on the shared line answers, bridge forwards each
   always @(negedge i_halt_n) begin
      if (i_resetn && i_on) begin
         grant_one();
         if (i_two) grant_one();
      end
   end
endmodule
